// >>> rtl/smr_sleep_reset_ctrl.sv
// Operation
// - five software selected sleep states: idle, adc noise, power-save, power-down, standby
// - idle stops only cpu clock; sram, timers, spi, interrupts keep running
// - power-down keeps registers, stops oscillator; wake by interrupt or reset
// - power-save keeps the asynchronous timer counting
// - adc noise mode stops cpu and io except async timer and converter
// - standby keeps crystal oscillator running so wake needs no start-up
// - ports b(8), c(7), d(8) bidirectional with individual pull-ups
// - any reset tri-states all port pins asynchronously, clock or not
// - reset-disable fuse: pc6 plain io when programmed, else active-low reset
// - reset pin low beyond minimum pulse resets device without clock
// - clock fuses give pb6 amplifier/clock input, pb7 amplifier output
// - internal rc plus async select: pb6/pb7 become async timer oscillator pins
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module smr_sleep_reset_ctrl (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic sleep_req,
	input wire logic wake_irq,
	input wire logic reset_pin_disable_fuse,
	input wire logic [3:0] clock_sel_fuse,
	input wire logic [7:0] pb_in,
	input wire logic [6:0] pc_in,
	input wire logic [7:0] pd_in,
	output logic [7:0] pb_out,
	output logic [7:0] pb_oe,
	output logic [7:0] pb_pu,
	output logic [6:0] pc_out,
	output logic [6:0] pc_oe,
	output logic [6:0] pc_pu,
	output logic [7:0] pd_out,
	output logic [7:0] pd_oe,
	output logic [7:0] pd_pu,
	output smr_pkg::smr_clken_t clken,
	output logic cpu_resume,
	output logic core_rst_n,
	output logic crystal_amp_en,
	output logic ext_clk_in_en,
	output logic timer_osc_en
);

	// clock enables per sleep mode; reserved codes behave as idle
	function automatic smr_pkg::smr_clken_t mode_clken(input logic [2:0] m);
		smr_pkg::smr_clken_t c;
		c = smr_pkg::CLKEN_ALL;
		case (m)
			smr_pkg::MODE_ADC_NR: begin
				c.timer = 1'b0;
				c.spi = 1'b0;
				c.cpu = 1'b0;
			end
			smr_pkg::MODE_PDOWN: begin
				c = '0;
				c.irq = 1'b1;
			end
			smr_pkg::MODE_PSAVE: begin
				c = '0;
				c.irq = 1'b1;
				c.atimer = 1'b1;
			end
			smr_pkg::MODE_STANDBY: begin
				c = '0;
				c.irq = 1'b1;
				c.osc = 1'b1;
			end
			default: begin
				c.cpu = 1'b0;
			end
		endcase
		return c;
	endfunction : mode_clken

	function automatic logic [7:0] port_mask(input logic [1:0] p);
		logic [7:0] m;
		m = smr_pkg::PORT_B_MASK;
		case (p)
			2'h1: m = smr_pkg::PORT_C_MASK;
			2'h2: m = smr_pkg::PORT_D_MASK;
			default: m = smr_pkg::PORT_B_MASK;
		endcase
		return m;
	endfunction : port_mask

	// reset pin shares pc6; with the disable fuse unprogrammed, a low pin clears every flop at once, no clock needed
	wire logic rst_pin_used = ~reset_pin_disable_fuse;
	wire logic rst_n = hresetn & (reset_pin_disable_fuse | pc_in[6]);

	logic [3:0] sleep_ctrl_r;
	logic async_sel_r;
	logic [7:0] out_r [smr_pkg::NUM_PORTS];
	logic [7:0] dir_r [smr_pkg::NUM_PORTS];
	logic [7:0] pu_r [smr_pkg::NUM_PORTS];
	smr_pkg::smr_state_t state_r;
	smr_pkg::smr_state_t state_nxt;
	logic [7:0] start_cnt_r;
	logic [7:0] start_cnt_nxt;
	logic [2:0] slept_mode_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;

	// ahb decode
	wire logic addr_ph = hsel & hready & htrans[1];
	wire logic [7:0] a_addr = haddr[7:0];
	wire logic [2:0] mode = sleep_ctrl_r[smr_pkg::SLP_MODE_LSB +: 3];
	wire logic sleep_en = sleep_ctrl_r[smr_pkg::SLP_EN_BIT];
	wire logic [7:0] pins [smr_pkg::NUM_PORTS];
	assign pins[0] = pb_in;
	assign pins[1] = {1'b0, pc_in};
	assign pins[2] = pd_in;

	function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [31:0] stat,
		input logic [3:0] sc, input logic as, input logic [7:0] o, input logic [7:0] d,
		input logic [7:0] u, input logic [7:0] p);
		logic [31:0] r;
		r = 32'h0;
		if (a == smr_pkg::ADDR_SLEEP_CTRL) begin
			r = {28'h0, sc};
		end else if (a == smr_pkg::ADDR_ASYNC_TMR) begin
			r = {28'h0, as, 3'h0};
		end else if (a == smr_pkg::ADDR_STATUS) begin
			r = stat;
		end else if (a[7:6] == 2'h0 && a[5:4] != 2'h0) begin
			case (a[3:2])
				smr_pkg::PORT_OUT: r = {24'h0, o};
				smr_pkg::PORT_DIR: r = {24'h0, d};
				smr_pkg::PORT_PU: r = {24'h0, u};
				default: r = {24'h0, p};
			endcase
		end
		return r;
	endfunction : read_mux

	wire logic [1:0] a_port = 2'(a_addr[5:4] - 2'h1);
	wire logic a_port_ok = a_addr[7:6] == 2'h0 && a_addr[5:4] != 2'h0;
	wire logic [1:0] w_port = 2'(wr_addr_r[5:4] - 2'h1);
	wire logic w_port_ok = wr_addr_r[7:6] == 2'h0 && wr_addr_r[5:4] != 2'h0;
	wire logic [1:0] rp = a_port_ok ? a_port : 2'h0;
	wire logic [31:0] status_w = {20'h0, clken, state_r};
	wire logic [31:0] rd_w = read_mux(a_addr, status_w, sleep_ctrl_r, async_sel_r,
		out_r[rp], dir_r[rp], pu_r[rp], pins[rp] & port_mask(rp));

	// oscillator pin use
	wire logic ck_rc = clock_sel_fuse != smr_pkg::CKSEL_EXT &&
		clock_sel_fuse <= smr_pkg::CKSEL_RC_MAX;
	wire logic ck_ext = clock_sel_fuse == smr_pkg::CKSEL_EXT;
	wire logic ck_xtal = ~ck_rc & ~ck_ext;
	wire logic tosc_use = ck_rc & async_sel_r;
	wire logic pb6_taken = ck_xtal | ck_ext | tosc_use;
	wire logic pb7_taken = ck_xtal | tosc_use;
	wire logic [7:0] pb_taken = {pb7_taken, pb6_taken, 6'h0};
	wire logic [6:0] pc_taken = {rst_pin_used, 6'h0};

	// sleep sequencing
	// mode may be written just before sleep is taken, so read it live while active
	wire logic [2:0] clk_mode = state_r == smr_pkg::ST_ACTIVE ? mode : slept_mode_r;
	wire smr_pkg::smr_clken_t sleep_clken = mode_clken(clk_mode);
	wire logic osc_was_off = slept_mode_r == smr_pkg::MODE_PDOWN ||
		slept_mode_r == smr_pkg::MODE_PSAVE;
	always_comb begin
		state_nxt = state_r;
		start_cnt_nxt = start_cnt_r;
		case (state_r)
			smr_pkg::ST_ACTIVE: begin
				if (sleep_req && sleep_en) begin
					state_nxt = smr_pkg::ST_SLEEP;
				end
			end
			smr_pkg::ST_SLEEP: begin
				if (wake_irq) begin
					// standby skips the oscillator wait
					state_nxt = osc_was_off ? smr_pkg::ST_START : smr_pkg::ST_RESUME;
					start_cnt_nxt = 8'(smr_pkg::OSC_START_CYC);
				end
			end
			smr_pkg::ST_START: begin
				start_cnt_nxt = 8'(start_cnt_r - 8'h1);
				if (start_cnt_r <= 8'h1) begin
					state_nxt = smr_pkg::ST_RESUME;
				end
			end
			smr_pkg::ST_RESUME: begin
				state_nxt = smr_pkg::ST_ACTIVE;
			end
			default: begin
				state_nxt = smr_pkg::ST_ACTIVE;
			end
		endcase
	end

	smr_pkg::smr_clken_t clken_nxt;
	always_comb begin
		clken_nxt = smr_pkg::CLKEN_ALL;
		if (state_nxt == smr_pkg::ST_SLEEP) begin
			clken_nxt = sleep_clken;
		end else if (state_nxt == smr_pkg::ST_START) begin
			clken_nxt = sleep_clken;
			clken_nxt.osc = 1'b1;
		end else if (state_nxt == smr_pkg::ST_RESUME) begin
			clken_nxt = smr_pkg::CLKEN_ALL;
			clken_nxt.cpu = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= smr_pkg::ST_ACTIVE;
			start_cnt_r <= 8'h0;
			slept_mode_r <= smr_pkg::MODE_IDLE;
			clken <= smr_pkg::CLKEN_ALL;
			cpu_resume <= 1'b0;
		end else begin
			state_r <= state_nxt;
			start_cnt_r <= start_cnt_nxt;
			if (state_r == smr_pkg::ST_ACTIVE) begin
				slept_mode_r <= mode;
			end
			clken <= clken_nxt;
			cpu_resume <= state_r == smr_pkg::ST_RESUME;
		end
	end

	// ahb slave: zero wait, always okay
	always_ff @(posedge hclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h0;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_r <= addr_ph & hwrite;
			if (addr_ph) begin
				wr_addr_r <= a_addr;
			end
			if (addr_ph && !hwrite) begin
				hrdata <= rd_w;
			end
		end
	end

	// register writes; all port state clears on any reset
	always_ff @(posedge hclk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_ctrl_r <= smr_pkg::SLEEP_CTRL_RST;
			async_sel_r <= 1'b0;
			for (int i = 0; i < smr_pkg::NUM_PORTS; i++) begin
				out_r[i] <= 8'h0;
				dir_r[i] <= 8'h0;
				pu_r[i] <= 8'h0;
			end
		end else if (wr_pend_r) begin
			if (wr_addr_r == smr_pkg::ADDR_SLEEP_CTRL) begin
				sleep_ctrl_r <= hwdata[3:0];
			end
			if (wr_addr_r == smr_pkg::ADDR_ASYNC_TMR) begin
				async_sel_r <= hwdata[smr_pkg::ASYNC_SEL_BIT];
			end
			if (w_port_ok) begin
				case (wr_addr_r[3:2])
					smr_pkg::PORT_OUT: out_r[w_port] <= hwdata[7:0] & port_mask(w_port);
					smr_pkg::PORT_DIR: dir_r[w_port] <= hwdata[7:0] & port_mask(w_port);
					smr_pkg::PORT_PU: pu_r[w_port] <= hwdata[7:0] & port_mask(w_port);
					default: ;
				endcase
			end
		end
	end

	// pin drivers; pull-up only on inputs not claimed by oscillator; the reset input has one outside reset
	always_ff @(posedge hclk or negedge rst_n) begin
		if (!rst_n) begin
			pb_oe <= 8'h0;
			pc_oe <= 7'h0;
			pd_oe <= 8'h0;
			pb_out <= 8'h0;
			pc_out <= 7'h0;
			pd_out <= 8'h0;
			pb_pu <= 8'h0;
			pc_pu <= 7'h0;
			pd_pu <= 8'h0;
			core_rst_n <= 1'b0;
			crystal_amp_en <= 1'b0;
			ext_clk_in_en <= 1'b0;
			timer_osc_en <= 1'b0;
		end else begin
			pb_oe <= dir_r[0] & ~pb_taken;
			pc_oe <= dir_r[1][6:0] & ~pc_taken;
			pd_oe <= dir_r[2];
			pb_out <= out_r[0];
			pc_out <= out_r[1][6:0];
			pd_out <= out_r[2];
			pb_pu <= pu_r[0] & ~dir_r[0] & ~pb_taken;
			// reset input keeps its pull-up
			pc_pu <= (pu_r[1][6:0] & ~dir_r[1][6:0] & ~pc_taken) | pc_taken;
			pd_pu <= pu_r[2] & ~dir_r[2];
			core_rst_n <= 1'b1;
			// amplifier stops with the oscillator in deep sleep
			crystal_amp_en <= ck_xtal & clken_nxt.osc;
			ext_clk_in_en <= ck_ext & clken_nxt.osc;
			timer_osc_en <= tosc_use & clken_nxt.atimer;
		end
	end

endmodule : smr_sleep_reset_ctrl
`default_nettype wire

// >>> inc/smr_pkg.sv
package smr_pkg;
	// ahb byte addresses
	localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ASYNC_TMR = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_PORT_BASE = 8'h10;
	// port block: out, dir, pull-up, pins; 0x10 apart per port b, c, d
	localparam int PORT_STRIDE_SH = 4;
	localparam logic [1:0] PORT_OUT = 2'h0;
	localparam logic [1:0] PORT_DIR = 2'h1;
	localparam logic [1:0] PORT_PU = 2'h2;
	localparam logic [1:0] PORT_PIN = 2'h3;
	localparam int NUM_PORTS = 3;
	localparam logic [7:0] PORT_B_MASK = 8'hff;
	localparam logic [7:0] PORT_C_MASK = 8'h7f;
	localparam logic [7:0] PORT_D_MASK = 8'hff;
	// sleep control fields and async timer select bit
	localparam int SLP_EN_BIT = 0;
	localparam int SLP_MODE_LSB = 1;
	localparam int ASYNC_SEL_BIT = 3;
	localparam logic [3:0] SLEEP_CTRL_RST = 4'h0;
	// sleep mode codes
	localparam logic [2:0] MODE_IDLE = 3'h0;
	localparam logic [2:0] MODE_ADC_NR = 3'h1;
	localparam logic [2:0] MODE_PDOWN = 3'h2;
	localparam logic [2:0] MODE_PSAVE = 3'h3;
	localparam logic [2:0] MODE_STANDBY = 3'h6;
	// clock select fuse: 0 external clock, 1..4 internal rc, else crystal
	localparam logic [3:0] CKSEL_EXT = 4'h0;
	localparam logic [3:0] CKSEL_RC_MAX = 4'h4;
	// oscillator restart wait after power-down or power-save
	localparam int OSC_START_NS = 800;
	localparam int CLK_MHZ = 20;
	localparam int OSC_START_CYC = (OSC_START_NS * CLK_MHZ + 999) / 1000;
	// shortest low on the reset pin that is sure to reset
	localparam int RST_MIN_NS = 1500;

	typedef struct packed {
		logic osc;
		logic atimer;
		logic adc;
		logic irq;
		logic spi;
		logic timer;
		logic mem;
		logic cpu;
	} smr_clken_t;

	localparam smr_clken_t CLKEN_ALL = 8'hff;

	typedef enum logic [3:0] {
		ST_ACTIVE = 4'h1,
		ST_SLEEP = 4'h2,
		ST_START = 4'h4,
		ST_RESUME = 4'h8
	} smr_state_t;
endpackage : smr_pkg

// >>> dv/smr_sleep_reset_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module smr_sleep_reset_ctrl_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire smr_pkg::smr_clken_t clken,
	input wire logic cpu_resume,
	input wire logic core_rst_n,
	input wire logic [7:0] pb_oe,
	input wire logic [6:0] pc_oe,
	input wire logic [7:0] pd_oe,
	input wire logic [6:0] pc_pu,
	input wire logic reset_pin_disable_fuse,
	input wire logic [3:0] clock_sel_fuse,
	input wire logic crystal_amp_en
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_SLEEP_SET: assert property (!clken.cpu |-> clken inside
		{8'hfe, 8'hf2, 8'h10, 8'h50, 8'h90, 8'hd0})
		else $error("clock pattern off");
	AST_IDLE_RUN: assert property (clken.timer && !clken.cpu |-> clken == 8'hfe)
		else $error("idle pattern off");
	AST_ADC_ONLY: assert property (clken.adc && !clken.timer |-> clken == 8'hf2)
		else $error("adc noise pattern off");
	AST_OSC_WAKE: assert property ($rose(clken.osc) && !clken.cpu |->
		##16 clken == 8'hfe ##1 cpu_resume) else $error("oscillator restart off");
	AST_RESUME: assert property ($rose(cpu_resume) |-> clken == 8'hff &&
		$past(clken) == 8'hfe) else $error("resume order off");
	AST_PULSE: assert property (cpu_resume |=> !cpu_resume)
		else $error("resume pulse too long");
	AST_TRISTATE: assert property (!core_rst_n |-> {pb_oe, pc_oe, pd_oe} == 23'h0)
		else $error("pin driven in reset");
	AST_RST_PIN: assert property (core_rst_n && $past(core_rst_n) &&
		!reset_pin_disable_fuse && $stable(reset_pin_disable_fuse)
		|-> !pc_oe[6] && pc_pu[6]) else $error("reset pin driven");
	AST_XTAL: assert property (core_rst_n && $past(core_rst_n) &&
		clock_sel_fuse > 4'h4 && $stable(clock_sel_fuse) && clken.osc
		|-> crystal_amp_en && pb_oe[7:6] == 2'h0) else $error("crystal pins off");
endmodule : smr_sleep_reset_ctrl_chk
bind smr_sleep_reset_ctrl smr_sleep_reset_ctrl_chk u_smr_sleep_reset_ctrl_chk (.*);
`default_nettype wire

// >>> dv/smr_board_model.sv
`timescale 1ns/100ps
`default_nettype none
module smr_board_model (
	input wire logic hclk,
	input wire logic rst_go,
	input wire logic [6:0] pc_out,
	input wire logic [6:0] pc_oe,
	input wire logic [6:0] pc_pu,
	output logic [6:0] pc_in
);
	logic [5:0] hold_r = 6'h0;
	// low for 40 cycles, well past the 30-cycle minimum
	always @(posedge hclk) begin
		if (rst_go)
			hold_r <= 6'h28;
		else if (hold_r != 6'h0)
			hold_r <= hold_r - 6'h1;
	end
	// a released line shows pull-up, else inverse of last value
	assign pc_in[5:0] = (pc_oe[5:0] & pc_out[5:0]) | (~pc_oe[5:0] & (pc_pu[5:0] | ~pc_out[5:0]));
	assign pc_in[6] = pc_oe[6] ? pc_out[6] : (hold_r == 6'h0);
endmodule : smr_board_model
`default_nettype wire

// >>> dv/smr_sleep_reset_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module smr_sleep_reset_ctrl_tb;
	logic hclk, hresetn, hwrite, hreadyout, hresp, sleep_req, wake_irq, rst_go;
	logic hsel = 1'b1;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic reset_pin_disable_fuse, cpu_resume, core_rst_n;
	logic crystal_amp_en, ext_clk_in_en, timer_osc_en;
	logic [3:0] clock_sel_fuse;
	logic [7:0] pb_in, pb_out, pb_oe, pb_pu, pd_in, pd_out, pd_oe, pd_pu;
	logic [6:0] pc_in, pc_out, pc_oe, pc_pu;
	smr_pkg::smr_clken_t clken;
	wire logic hready = hreadyout;
	int n_mismatch = 0;
	int compares = 0;
	smr_sleep_reset_ctrl u_smr_sleep_reset_ctrl (.*);
	smr_board_model u_smr_board_model (.*);
	assign pb_in = (pb_out & pb_oe) | (pb_pu & ~pb_oe);
	assign pd_in = (pd_out & pd_oe) | (pd_pu & ~pd_oe);
	always #25 hclk = ~hclk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge hclk);
		haddr <= 32'(a);
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask : rd
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : tick
	task automatic nap(input logic [2:0] m, input logic [7:0] pat);
		int n;
		int e;
		n = 0;
		e = (m == smr_pkg::MODE_PDOWN || m == smr_pkg::MODE_PSAVE) ?
			smr_pkg::OSC_START_CYC + 1 : 1;
		wr(8'h00, {28'h0, m, 1'b1});
		@(posedge hclk);
		sleep_req <= 1'b1;
		@(posedge hclk);
		sleep_req <= 1'b0;
		tick(3);
		chk(32'(clken), 32'(pat));
		wake_irq <= 1'b1;
		@(posedge hclk);
		wake_irq <= 1'b0;
		#1;
		while (n < 40 && cpu_resume !== 1'b1) begin
			tick(1);
			n++;
		end
		chk(32'(clken), 32'hff);
		chk(32'(n), 32'(e));
		tick(1);
		chk(32'(cpu_resume), 32'h0);
	endtask : nap
	task automatic give_verdict;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		hclk = 1'b0;
		{hresetn, hwrite, sleep_req, wake_irq, rst_go, reset_pin_disable_fuse} = 6'h0;
		{haddr, hwdata, htrans} = 66'h0;
		clock_sel_fuse = 4'h1;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rd(8'h08, 32'hff1);
		for (int p = 0; p < 3; p++) begin
			wr(8'(8'h14 + p * 16), 32'hff);
			wr(8'(8'h10 + p * 16), 32'ha5);
		end
		rd(8'h20, 32'h25);
		rd(8'h3c, 32'ha5);
		chk(32'({pb_oe, pc_oe, pd_oe}), 32'h7fbfff);
		chk(32'({pb_out, pc_out, pd_out}), 32'h52a5a5);
		wr(8'h38, 32'hff);
		wr(8'h34, 32'h0);
		tick(2);
		chk(32'(pd_pu), 32'hff);
		wr(8'h04, 32'h8);
		tick(2);
		chk(32'({timer_osc_en, pb_oe}), 32'h13f);
		rd(8'h04, 32'h8);
		clock_sel_fuse <= 4'h5;
		tick(3);
		chk(32'({crystal_amp_en, pb_oe}), 32'h13f);
		clock_sel_fuse <= 4'h0;
		tick(3);
		chk(32'({ext_clk_in_en, pb_oe}), 32'h1bf);
		nap(smr_pkg::MODE_IDLE, 8'hfe);
		nap(smr_pkg::MODE_ADC_NR, 8'hf2);
		nap(smr_pkg::MODE_PDOWN, 8'h10);
		nap(smr_pkg::MODE_PSAVE, 8'h50);
		nap(smr_pkg::MODE_STANDBY, 8'h90);
		wr(8'h00, 32'h4);
		sleep_req <= 1'b1;
		tick(2);
		chk(32'(clken), 32'hff);
		sleep_req <= 1'b0;
		rd(8'h40, 32'h0);
		rd(8'h00, 32'h4);
		rd(8'h5c, 32'h0);
		rst_go <= 1'b1;
		@(posedge hclk);
		rst_go <= 1'b0;
		tick(3);
		chk(32'({core_rst_n, pb_oe}), 32'h0);
		tick(50);
		rd(8'h14, 32'h0);
		reset_pin_disable_fuse <= 1'b1;
		wr(8'h24, 32'h40);
		tick(2);
		chk(32'(pc_oe), 32'h40);
		give_verdict();
	end
	initial begin
		#2000000;
		n_mismatch++;
		give_verdict();
	end
endmodule : smr_sleep_reset_ctrl_tb
`default_nettype wire
